// ### hw/pmc_regs.sv
/*
  Power-management control/status and MSI capability registers of one
  switch port, reached over AXI4-Lite, plus the MSI write request and PME
  message request that the port issues.
  Assumes a single 50 MHz clock; event and sticky-reset inputs are
  synchronous to aclk. The message request side is a valid/ready pair.
*/
`timescale 1ns/1ps
`include "pmc_consts.svh"
module pmc_regs
  import pmc_pkg::*;
#(
  parameter bit UPSTREAM_PORT = 1'b0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic sticky_resetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic pme_event,
  input wire logic pme_forwarded,
  input wire logic msi_request,
  output logic msi_valid,
  output logic [63:0] msi_addr,
  output logic msi_wide,
  output logic [31:0] msi_data,
  output logic msi_to_upstream,
  input wire logic msi_ready,
  output logic pme_msg_valid,
  input wire logic pme_msg_ready,
  output logic [1:0] power_state,
  output logic ctx_preserved
);

  pmc_state_type st;
  pmc_state_type next_st;

  // ==========================================
  // Helpers
  function automatic logic [31:0] pmc_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                            input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic pmc_mapped(input logic [7:0] a);
    return (a == `PMC_OFF_PMCS) || (a == `PMC_OFF_MSI_CAPABILITY_CONTROL) || (a == `PMC_OFF_MSI_LOWER_ADDRESS) ||
           (a == `PMC_OFF_MSIUADDR) || (a == `PMC_OFF_MSIDATA);
  endfunction

  function automatic logic [31:0] pmc_read(input pmc_state_type s, input logic [7:0] a);
    logic [31:0] r;
    r = 32'h00000000;
    case ({a[7:2], 2'b00})
      `PMC_OFF_PMCS: begin
        r[1:0] = s.power_state; // RULE_01
        r[`PMC_BIT_CTX] = s.ctx_preserved;
        r[`PMC_BIT_WAKE_EN] = s.wake_enable;
        r[`PMC_BIT_WAKE_FLAG] = s.wake_flag;
        // Data, scale, select, B2/B3 and bus power bits stay zero RULE_10 RULE_11
      end
      `PMC_OFF_MSI_CAPABILITY_CONTROL: begin
        r[7:0] = `PMC_CAP_CODE; // RULE_12
        r[15:8] = s.next_link;
        r[`PMC_BIT_MSI_EN] = s.msi_enable;
        r[19:17] = 3'h0; // RULE_15
        r[22:20] = `PMC_MULTI_ONE; // RULE_15
        r[`PMC_BIT_WIDE] = 1'b1; // RULE_16
      end
      `PMC_OFF_MSI_LOWER_ADDRESS: begin
        r = {s.addr_low, 2'b00}; // RULE_17
      end
      `PMC_OFF_MSIUADDR: begin
        r = s.addr_high;
      end
      `PMC_OFF_MSIDATA: begin
        r = {16'h0000, s.payload};
      end
      default: begin
        r = 32'h00000000;
      end
    endcase
    return r;
  endfunction

  // ==========================================
  // Next state
  always_comb begin
    logic [31:0] wv;
    logic [31:0] cur;
    logic do_write;
    logic wake_clear;
    wv = 32'h00000000;
    cur = 32'h00000000;
    do_write = 1'b0;
    wake_clear = 1'b0;
    next_st = st;

    // Write channel: address and data taken in either order
    if (s_axi_awvalid && !st.aw_held && st.wr_state == PMC_WR_IDLE) begin
      next_st.aw_held = 1'b1;
      next_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st.w_held && st.wr_state == PMC_WR_IDLE) begin
      next_st.w_held = 1'b1;
      next_st.w_data = s_axi_wdata;
      next_st.w_strb = s_axi_wstrb;
    end

    case (st.wr_state)
      PMC_WR_IDLE: begin
        if (st.aw_held && st.w_held) begin
          do_write = pmc_mapped({st.aw_addr[7:2], 2'b00});
          next_st.aw_held = 1'b0;
          next_st.w_held = 1'b0;
          next_st.bvalid = 1'b1;
          next_st.bresp = do_write ? 2'b00 : 2'b10;
          next_st.wr_state = PMC_WR_RESP;
        end
      end
      PMC_WR_RESP: begin
        if (s_axi_bready) begin
          next_st.bvalid = 1'b0;
          next_st.wr_state = PMC_WR_IDLE;
        end
      end
      default: begin
        next_st.wr_state = PMC_WR_IDLE;
      end
    endcase

    if (do_write) begin
      cur = pmc_read(st, st.aw_addr);
      wv = pmc_merge(cur, st.w_data, st.w_strb);
      case ({st.aw_addr[7:2], 2'b00})
        `PMC_OFF_PMCS: begin
          // Reserved codes are dropped so the port stays in its state RULE_01 RULE_02
          if (st.w_strb[0] && (wv[1:0] == `PMC_PS_D0 || wv[1:0] == `PMC_PS_D3HOT)) begin
            next_st.power_state = wv[1:0];
          end
          next_st.wake_enable = wv[`PMC_BIT_WAKE_EN]; // RULE_04
          wake_clear = st.w_strb[1] && st.w_data[`PMC_BIT_WAKE_FLAG]; // RULE_07
        end
        `PMC_OFF_MSI_CAPABILITY_CONTROL: begin
          next_st.msi_enable = wv[`PMC_BIT_MSI_EN]; // RULE_14
        end
        `PMC_OFF_MSI_LOWER_ADDRESS: begin
          next_st.addr_low = wv[31:2]; // RULE_17
        end
        `PMC_OFF_MSIUADDR: begin
          next_st.addr_high = wv;
        end
        `PMC_OFF_MSIDATA: begin
          next_st.payload = wv[15:0];
        end
        default: begin
          next_st.payload = st.payload;
        end
      endcase
    end

    // Own PME sets the flag even with enable clear; set beats a same-cycle clear.
    // Forwarded messages are not looked at here. RULE_07 RULE_08 RULE_09
    if (pme_event && !UPSTREAM_PORT) begin
      next_st.wake_flag = 1'b1;
    end else if (wake_clear) begin
      next_st.wake_flag = 1'b0;
    end

    // PME message only while enabled RULE_04
    if (st.pme_valid && pme_msg_ready) begin
      next_st.pme_valid = 1'b0;
    end
    if (pme_event && !UPSTREAM_PORT && st.wake_enable) begin
      next_st.pme_valid = 1'b1;
    end

    // Read channel: one cycle to answer
    if (st.rvalid) begin
      if (s_axi_rready) begin
        next_st.rvalid = 1'b0;
      end
    end else if (s_axi_arvalid) begin
      next_st.rvalid = 1'b1;
      next_st.rdata = pmc_read(st, s_axi_araddr);
      next_st.rresp = pmc_mapped({s_axi_araddr[7:2], 2'b00}) ? 2'b00 : 2'b10;
    end

    // MSI write request, captured from the registers at the request
    case (st.msi_state)
      PMC_MSI_IDLE: begin
        if (msi_request && st.msi_enable) begin // RULE_22
          next_st.msi_valid = 1'b1;
          next_st.msi_wide = (st.addr_high != 32'h00000000); // RULE_20
          next_st.msi_addr = {st.addr_high, st.addr_low, 2'b00};
          next_st.msi_data = {16'h0000, st.payload}; // RULE_21
          next_st.msi_state = PMC_MSI_BUSY;
        end
      end
      PMC_MSI_BUSY: begin
        if (msi_ready) begin
          next_st.msi_valid = 1'b0;
          next_st.msi_state = PMC_MSI_IDLE;
        end
      end
      default: begin
        next_st.msi_state = PMC_MSI_IDLE;
      end
    endcase

    // Ready flags are registered from the next state so every port comes from a flop
    next_st.awready = !next_st.aw_held && next_st.wr_state == PMC_WR_IDLE;
    next_st.wready = !next_st.w_held && next_st.wr_state == PMC_WR_IDLE;
    next_st.arready = !next_st.rvalid;
    next_st.to_root = !UPSTREAM_PORT;

    // Sticky bits survive aresetn; only sticky_resetn clears them RULE_05
    if (!sticky_resetn) begin
      next_st.wake_enable = 1'b0;
      next_st.wake_flag = 1'b0;
    end
  end

  // ==========================================
  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= next_st;
      st.wr_state <= PMC_WR_IDLE;
      st.aw_held <= 1'b0;
      st.aw_addr <= 8'h00;
      st.w_held <= 1'b0;
      st.w_data <= 32'h00000000;
      st.w_strb <= 4'h0;
      st.bvalid <= 1'b0;
      st.bresp <= 2'h0;
      st.rvalid <= 1'b0;
      st.rdata <= 32'h00000000;
      st.rresp <= 2'h0;
      st.power_state <= `PMC_PS_D0;
      st.ctx_preserved <= `PMC_CTX_RESET; // RULE_03
      st.next_link <= `PMC_NEXT_LINK_RESET; // RULE_13
      st.msi_enable <= 1'b0; // RULE_14
      st.addr_low <= 30'h00000000;
      st.addr_high <= 32'h00000000;
      st.payload <= 16'h0000;
      st.msi_state <= PMC_MSI_IDLE;
      st.msi_valid <= 1'b0;
      st.msi_addr <= 64'h0000000000000000;
      st.msi_wide <= 1'b0;
      st.msi_data <= 32'h00000000;
      st.pme_valid <= 1'b0;
      st.awready <= 1'b1;
      st.wready <= 1'b1;
      st.arready <= 1'b1;
      st.to_root <= !UPSTREAM_PORT;
      if (!sticky_resetn) begin
        st.wake_enable <= 1'b0;
        st.wake_flag <= 1'b0;
      end
    end else begin
      st <= next_st;
    end
  end

  // ==========================================
  // Outputs
  assign s_axi_awready = st.awready;
  assign s_axi_wready = st.wready;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = st.arready;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;
  assign msi_valid = st.msi_valid;
  // Upper half is zero when narrow: it is captured from the zero upper register RULE_20
  assign msi_addr = st.msi_addr;
  assign msi_wide = st.msi_wide;
  assign msi_data = st.msi_data;
  // Downstream-port messages always head for the root RULE_18
  assign msi_to_upstream = st.to_root;
  assign pme_msg_valid = st.pme_valid;
  assign power_state = st.power_state;
  assign ctx_preserved = st.ctx_preserved;

endmodule

// ### include/pmc_consts.svh
/*
  Register offsets, field positions, reset values and fixed codes for the
  power-management and MSI configuration block.
  Assumes inclusion by bare name from the package and the design file.
*/
// Behaviour
// RULE_01 - Two-bit power state reads present state; writes request D0 or D3hot.
// RULE_02 - Codes one and two are reserved; the port never enters them.
// RULE_03 - Context-preserved flag at bit three resets to one.
// RULE_04 - Sticky wake-message enable at bit eight permits PME message generation.
// RULE_05 - Hot reset leaves wake-message enable unchanged; only sticky reset clears it.
// RULE_06 - Initialising agent should set wake-message enable from EEPROM for hot-plug wake.
// RULE_07 - Sticky wake-event flag at bit fifteen sets on own PME; write one clears.
// RULE_08 - Forwarded PME messages leave the wake-event flag untouched.
// RULE_09 - On the upstream port the wake-event flag never sets.
// RULE_10 - Data select, data scale and data fields read zero.
// RULE_11 - Bus power/clock control and B2/B3 support bits read zero.
// RULE_12 - MSI capability low byte reads fixed code five.
// RULE_13 - Next-capability link in bits fifteen to eight resets to zero.
// RULE_14 - MSI enable at bit sixteen is read-write and resets to zero.
// RULE_15 - Multi-vector capable reads zero; granted field fixed to one message.
// RULE_16 - Wide-address-capable bit twenty-three reads one.
// RULE_17 - Lower address holds bits thirty-one to two; bits one to zero read zero.
// RULE_18 - Downstream-port interrupt writes are routed upstream whatever the address.
// RULE_19 - Software programs a downstream interrupt address only with upstream-routing values.
// RULE_20 - Nonzero upper address selects a 64-bit message write, else 32-bit.
// RULE_21 - Message write carries the sixteen-bit payload in its low half.
// RULE_22 - Interrupt writes are issued only while MSI enable is set.
`ifndef PMC_CONSTS_SVH
`define PMC_CONSTS_SVH

// ==========================================
// Register byte offsets
`define PMC_OFF_PMCS 8'hc4
`define PMC_OFF_MSI_CAPABILITY_CONTROL 8'hd0
`define PMC_OFF_MSI_LOWER_ADDRESS 8'hd4
`define PMC_OFF_MSIUADDR 8'hd8
`define PMC_OFF_MSIDATA 8'hdc

// ==========================================
// Field positions
`define PMC_BIT_CTX 3
`define PMC_BIT_WAKE_EN 8
`define PMC_BIT_WAKE_FLAG 15
`define PMC_BIT_MSI_EN 16
`define PMC_BIT_WIDE 23

// ==========================================
// Codes and reset values
`define PMC_PS_D0 2'h0
`define PMC_PS_D3HOT 2'h3
`define PMC_CTX_RESET 1'h1
`define PMC_CAP_CODE 8'h05
`define PMC_NEXT_LINK_RESET 8'h00
`define PMC_MULTI_ONE 3'h0

`endif

// ### include/pmc_pkg.sv
/*
  Types for the power-management and MSI configuration block.
  Assumes the constants header is on the include path.
*/
package pmc_pkg;
`include "pmc_consts.svh"

  typedef enum logic [1:0] {
    PMC_WR_IDLE = 2'b00,
    PMC_WR_RESP = 2'b01
  } pmc_wr_state_type;

  typedef enum logic [1:0] {
    PMC_MSI_IDLE = 2'b00,
    PMC_MSI_BUSY = 2'b01
  } pmc_msi_state_type;

  typedef struct packed {
    pmc_wr_state_type wr_state;
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [1:0] power_state;
    logic ctx_preserved;
    logic wake_enable;
    logic wake_flag;
    logic [7:0] next_link;
    logic msi_enable;
    logic [29:0] addr_low;
    logic [31:0] addr_high;
    logic [15:0] payload;
    pmc_msi_state_type msi_state;
    logic msi_valid;
    logic [63:0] msi_addr;
    logic msi_wide;
    logic [31:0] msi_data;
    logic pme_valid;
    logic awready;
    logic wready;
    logic arready;
    logic to_root;
  } pmc_state_type;
endpackage

// ### dv/pmc_regs_chk.sv
/* Port-side assertions for pmc_regs.
   Assumes it is bound into pmc_regs and that aresetn is the hot reset. */
`timescale 1ns/1ps
module pmc_regs_chk #(
  parameter bit UPSTREAM_PORT = 1'b0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [1:0] power_state,
  input wire logic ctx_preserved,
  input wire logic msi_request,
  input wire logic msi_valid,
  input wire logic msi_ready,
  input wire logic [63:0] msi_addr,
  input wire logic msi_wide,
  input wire logic [31:0] msi_data,
  input wire logic msi_to_upstream,
  input wire logic pme_event,
  input wire logic pme_msg_valid
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================
  // Properties
  AST_PS_LEGAL: assert property (power_state != 2'h1 && power_state != 2'h2)
    else $error("power state in reserved code");
  AST_CTX_SET: assert property (ctx_preserved == 1'b1)
    else $error("context flag not one");
  AST_MSI_CAUSE: assert property ($rose(msi_valid) |-> $past(msi_request))
    else $error("message write without request");
  // A stalled write must not change under the root
  AST_MSI_HOLD: assert property (msi_valid && !msi_ready |=> msi_valid && $stable(msi_addr) && $stable(msi_data))
    else $error("message write changed while stalled");
  AST_MSI_ROUTE: assert property (msi_valid && !UPSTREAM_PORT |-> msi_to_upstream)
    else $error("message write not routed up");
  AST_MSI_NARROW: assert property (msi_valid && !msi_wide |-> msi_addr[63:32] == 32'h0)
    else $error("narrow write with upper bits");
  AST_MSI_ALIGN: assert property (msi_valid |-> msi_addr[1:0] == 2'h0 && msi_data[31:16] == 16'h0)
    else $error("message address or data malformed");
  AST_PME_CAUSE: assert property ($rose(pme_msg_valid) |-> $past(pme_event))
    else $error("wake message without event");
endmodule
bind pmc_regs pmc_regs_chk #(.UPSTREAM_PORT(UPSTREAM_PORT)) u_chk (
  .aclk(aclk), .aresetn(aresetn), .power_state(power_state), .ctx_preserved(ctx_preserved),
  .msi_request(msi_request), .msi_valid(msi_valid), .msi_ready(msi_ready), .msi_addr(msi_addr),
  .msi_wide(msi_wide), .msi_data(msi_data), .msi_to_upstream(msi_to_upstream),
  .pme_event(pme_event), .pme_msg_valid(pme_msg_valid));

// ### dv/pmc_root_model.sv
/* Root-complex stand-in that takes message writes and wake messages.
   Assumes valid is held until ready; slow stalls ready. */
`timescale 1ns/1ps
module pmc_root_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic slow,
  input wire logic msi_valid,
  input wire logic [63:0] msi_addr,
  input wire logic [31:0] msi_data,
  output logic msi_ready,
  input wire logic pme_msg_valid,
  output logic pme_msg_ready,
  output logic [63:0] got_addr,
  output logic [31:0] got_data,
  output logic [7:0] n_msi,
  output logic [7:0] n_pme
);
  logic [1:0] tick;
  // ==========================================
  // Acceptance
  // When slow, one cycle in four accepts, so requests must hold
  assign msi_ready = !slow || tick == 2'h3;
  assign pme_msg_ready = msi_ready;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick <= 2'h0;
      n_msi <= 8'h00;
      n_pme <= 8'h00;
      got_addr <= 64'h0;
      got_data <= 32'h0;
    end else begin
      tick <= tick + 2'h1;
      if (msi_valid && msi_ready) begin
        n_msi <= n_msi + 8'h01;
        got_addr <= msi_addr;
        got_data <= msi_data;
      end
      if (pme_msg_valid && pme_msg_ready) begin
        n_pme <= n_pme + 8'h01;
      end
    end
  end
endmodule

// ### dv/pmc_regs_bench.sv
/* Self-checking bench for pmc_regs over AXI4-Lite with a root model.
   Assumes a 50 MHz aclk and byte offsets c4, d0, d4, d8, dc. */
`timescale 1ns/1ps
module pmc_regs_bench;
  logic aclk = 1'b0, aresetn = 1'b0, sticky_resetn = 1'b0, slow = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [2:0] ev = 3'h0;
  logic awready, wready, bvalid, arready, rvalid, mv, mr, mw, mu, pv, pr, ctx;
  logic [1:0] bresp, rresp, power_state_field;
  logic [31:0] rdata, md, got_data, up_rdata;
  logic [63:0] ma, got_addr;
  logic [7:0] n_msi, n_pme;
  int failures = 0, n_tests = 0;
  always #10 aclk = ~aclk;
  pmc_regs #(.UPSTREAM_PORT(1'b0)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .sticky_resetn(sticky_resetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .pme_event(ev[0]), .pme_forwarded(ev[1]), .msi_request(ev[2]), .msi_valid(mv), .msi_addr(ma),
    .msi_wide(mw), .msi_data(md), .msi_to_upstream(mu), .msi_ready(mr), .pme_msg_valid(pv),
    .pme_msg_ready(pr), .power_state(power_state_field), .ctx_preserved(ctx));
  pmc_root_model u_root (
    .aclk(aclk), .aresetn(aresetn), .slow(slow), .msi_valid(mv), .msi_addr(ma), .msi_data(md),
    .msi_ready(mr), .pme_msg_valid(pv), .pme_msg_ready(pr), .got_addr(got_addr),
    .got_data(got_data), .n_msi(n_msi), .n_pme(n_pme));
  // Upstream twin shares the bus and events; only its read data is compared
  pmc_regs #(.UPSTREAM_PORT(1'b1)) u_up (
    .aclk(aclk), .aresetn(aresetn), .sticky_resetn(sticky_resetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(),
    .s_axi_rdata(up_rdata), .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready(rready),
    .pme_event(ev[0]), .pme_forwarded(ev[1]), .msi_request(ev[2]), .msi_valid(), .msi_addr(),
    .msi_wide(), .msi_data(), .msi_to_upstream(), .msi_ready(mr), .pme_msg_valid(),
    .pme_msg_ready(pr), .power_state(), .ctx_preserved());
  // ==========================================
  // Tasks
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    while (!bvalid) @(posedge aclk);
    bready <= 1'b0;
    chk(64'(bresp), 64'(er));
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge aclk);
    rready <= 1'b0;
    chk(64'(rdata), 64'(ed));
    chk(64'(rresp), 64'(er));
  endtask
  task automatic pulse(input int i);
    @(posedge aclk);
    ev[i] <= 1'b1;
    @(posedge aclk);
    ev[i] <= 1'b0;
  endtask
  task automatic rst(input logic sticky);
    @(posedge aclk);
    aresetn <= 1'b0;
    sticky_resetn <= !sticky;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    sticky_resetn <= 1'b1;
  endtask
  task automatic wait_msi(input logic [7:0] k);
    for (int i = 0; i < 20 && n_msi !== k; i++) @(posedge aclk);
    chk(64'(n_msi), 64'(k));
  endtask
  task automatic close_out();
    if (failures == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ==========================================
  // Tests
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    sticky_resetn <= 1'b1;
    rd(8'hc4, 32'h00000008, 2'h0);
    chk(64'(ctx), 64'h1);
    rd(8'hd4, 32'h00000000, 2'h0);
    pulse(2);
    rd(8'hd0, 32'h00800005, 2'h0);
    chk(64'(n_msi), 64'h0);
    wr(8'hc4, 32'hffffffff, 2'h0);
    rd(8'hc4, 32'h0000010b, 2'h0);
    chk(64'(power_state_field), 64'h3);
    for (int i = 1; i < 3; i++) begin
      wr(8'hc4, 32'h00000100 | i, 2'h0);
      rd(8'hc4, 32'h0000010b, 2'h0);
    end
    wr(8'hc4, 32'h00000100, 2'h0);
    chk(64'(power_state_field), 64'h0);
    pulse(0);
    rd(8'hc4, 32'h00008108, 2'h0);
    chk(64'(up_rdata), 64'h00000108);
    chk(64'(n_pme), 64'h1);
    wr(8'hc4, 32'h00008000, 2'h0);
    rd(8'hc4, 32'h00000008, 2'h0);
    pulse(0);
    rd(8'hc4, 32'h00008008, 2'h0);
    chk(64'(n_pme), 64'h1);
    wr(8'hc4, 32'h00000100, 2'h0);
    rst(1'b0);
    rd(8'hc4, 32'h00008108, 2'h0);
    wr(8'hc4, 32'h00008100, 2'h0);
    pulse(1);
    rd(8'hc4, 32'h00000108, 2'h0);
    rst(1'b1);
    rd(8'hc4, 32'h00000008, 2'h0);
    wr(8'hd0, 32'hffffffff, 2'h0);
    rd(8'hd0, 32'h00810005, 2'h0);
    wr(8'hd4, 32'hffffffff, 2'h0);
    rd(8'hd4, 32'hfffffffc, 2'h0);
    wr(8'hd4, 32'h12345679, 2'h0);
    wr(8'hdc, 32'hffffabcd, 2'h0);
    pulse(2);
    wait_msi(8'h1);
    chk(got_addr, 64'h0000000012345678);
    chk(64'(got_data), 64'h0000abcd);
    chk(64'(mw), 64'h0);
    chk(64'(mu), 64'h1);
    slow <= 1'b1;
    wr(8'hd8, 32'h00000001, 2'h0);
    pulse(2);
    wait_msi(8'h2);
    chk(got_addr, 64'h0000000112345678);
    chk(64'(mw), 64'h1);
    rd(8'h00, 32'h00000000, 2'h2);
    wr(8'h00, 32'h00000000, 2'h2);
    close_out();
  end
  // Whole run is well under a thousand cycles; this cuts a hang
  initial begin
    #400000;
    failures++;
    close_out();
  end
endmodule
